// ---- logic/ddr3_seq_pkg.sv ----
// Shared constants and types for the DDR3 command sequencer.
// Assumes a 40 MHz core clock; all times are turned into cycles here.
package ddr3_seq_pkg;
  localparam int CLK_MHZ    = 40;
  // Refresh cycle, self-refresh exit and slow power-down exit times
  localparam int T_RFC_NS   = 110;
  localparam int T_XS_NS    = 120;
  localparam int T_XPDLL_NS = 24;
  localparam int RFC_CYC  = (T_RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int SR_CYC   = (T_XS_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOW_CYC = (T_XPDLL_NS * CLK_MHZ + 999) / 1000;
  localparam int PIPE_DEPTH = 32;
  localparam int NUM_BANKS  = 8;
  localparam logic [3:0] CHOP_CYC = 4'h2;  // Four beats, double rate
  localparam logic [3:0] FULL_CYC = 4'h4;
  // Controller keeps termination up this long after a write
  localparam logic [2:0] TERM_HOLD_CYC = 3'h6;
  // Register map
  localparam logic [3:0] ADDR_CFG  = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  // Burst field encodings of mode_register_zero
  localparam logic [1:0] BF_FULL = 2'h0;
  localparam logic [1:0] BF_FLY  = 2'h1;
  localparam logic [1:0] BF_CHOP = 2'h2;
  typedef enum logic [2:0] {
    CMD_NOOP, CMD_OPEN, CMD_PRE, CMD_READ, CMD_WRITE, CMD_REF, CMD_DES
  } cmd_t;
  typedef struct packed {
    logic       cke;
    logic       burst_chop_address_bit;
    logic [2:0] bank;
    cmd_t       cmd;
  } pins_t;
  // Layout of the config register, burst field in the low bits
  typedef struct packed {
    logic       slow_exit;
    logic [1:0] addlat_sel;
    logic [3:0] base_write_latency;
    logic [3:0] base_read_latency;
    logic [1:0] burst;
  } cfg_t;
  localparam int   CFG_W     = 13;
  localparam cfg_t CFG_RESET = 13'h0154;  // Eight beats, 5 and 5, no add
  typedef logic [PIPE_DEPTH-1:0][1:0] pipe_t;
  // Idle pin level: clock enabled, deselected
  localparam pins_t PINS_IDLE = '{cke: 1'b1,
                                  burst_chop_address_bit: 1'b0,
                                  bank: 3'h0,
                                  cmd: CMD_DES};
endpackage

// ---- logic/ddr3_seq.sv ----
// DDR3 device-side command sequencer: burst length, latencies,
// refresh, self-refresh and power-down states, termination timing.
// Assumes command pins arrive asynchronously and the register port
// runs on CLK_IN.
// Behaviour
// - Field 10, or field 01 with the chop bit low, gives a 4-beat burst.
// - Field 00, or field 01 with the chop bit high, gives an 8-beat burst.
// - In on-the-fly mode each command selects its own burst length.
// - Read data starts base read latency plus additive latency later.
// - Write data is expected base write latency plus additive latency later.
// - Power-down with a bank open is active power-down.
// - Precharge power-down exits fast or slow as configured.
// - Frozen-DLL power-down exit returns termination to sync after the window.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module ddr3_seq
  import ddr3_seq_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire pins_t       PINS_IN,
  input  wire logic [3:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [31:0] RDATA_OUT,
  output logic             RD_VALID_OUT,
  output logic             WR_WINDOW_OUT,
  output logic             PWR_DOWN_OUT,
  output logic             TERM_ASYNC_OUT
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_REFRESH, ST_OPEN_PD, ST_PRE_PD, ST_PD_EXIT,
    ST_SELF_REF, ST_SR_EXIT
  } st_t;

  // Chop decision; reserved field 11 falls back to eight beats
  function automatic logic chop_sel(logic [1:0] bf, logic bc);
    return (bf == BF_CHOP) || (bf == BF_FLY && !bc);
  endfunction

  // Shift the latency pipe and drop a new burst at its latency slot
  function automatic pipe_t step(pipe_t p, logic [4:0] lat, logic go,
                                 logic chop);
    pipe_t q;
    q = p >> 2;
    if (go) begin
      q[5'(lat - 5'h01)] = {1'b1, chop};
    end
    return q;
  endfunction

  // Burst data window length counter
  function automatic logic [3:0] cnt_step(logic [1:0] head,
                                          logic [3:0] cnt);
    if (head[1]) begin
      return head[0] ? CHOP_CYC : FULL_CYC;
    end
    return (cnt != 4'h0) ? 4'(cnt - 4'h1) : 4'h0;
  endfunction

  // Two-flop synchroniser for the command pins
  pins_t sync1_r;
  pins_t p;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      // Idle level, so release does not look like a clock-enable drop
      sync1_r <= PINS_IDLE;
      p       <= PINS_IDLE;
    end else begin
      sync1_r <= PINS_IN;
      p       <= sync1_r;
    end
  end

  // Register port: config write, status read
  cfg_t        cfg_r, cfg_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  st_t         st_r, st_nxt;
  logic [NUM_BANKS-1:0] open_r, open_nxt;
  logic        term_async_r, term_async_nxt;
  always_comb begin
    cfg_nxt   = cfg_r;
    rdata_nxt = rdata_r;
    if (WR_IN && ADDR_IN == ADDR_CFG) begin
      cfg_nxt = cfg_t'(WDATA_IN[CFG_W-1:0]);
    end
    if (RD_IN) begin
      unique case (ADDR_IN)
        ADDR_CFG:  rdata_nxt = {19'h0_0000, cfg_r};
        ADDR_STAT: rdata_nxt = {20'h0_0000, term_async_r, open_r, st_r};
        default:   rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cfg_r   <= CFG_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign RDATA_OUT = rdata_r;

  // Latencies derived from the configuration
  logic [4:0] addlat_w, rdlat_w, wrlat_w;
  logic       chop_w, rd_go, wr_go;
  always_comb begin
    unique case (cfg_r.addlat_sel)
      2'h1:    addlat_w = 5'(cfg_r.base_read_latency - 4'h1);
      2'h2:    addlat_w = 5'(cfg_r.base_read_latency - 4'h2);
      default: addlat_w = 5'h00;
    endcase
  end
  assign rdlat_w = 5'(cfg_r.base_read_latency) + addlat_w;
  assign wrlat_w = 5'(cfg_r.base_write_latency) + addlat_w;
  assign chop_w = chop_sel(cfg_r.burst,
                           p.burst_chop_address_bit);
  assign rd_go  = st_r == ST_IDLE && p.cke && p.cmd == CMD_READ;
  assign wr_go  = st_r == ST_IDLE && p.cke && p.cmd == CMD_WRITE;

  // Core state: latency pipes, bursts, power states, termination
  pipe_t      rd_pipe_r, rd_pipe_nxt, wr_pipe_r, wr_pipe_nxt;
  logic [3:0] rd_cnt_r, rd_cnt_nxt, wr_cnt_r, wr_cnt_nxt;
  logic [7:0] tmr_r, tmr_nxt;
  logic [4:0] win_r, win_nxt;
  logic       rd_on_r, wr_on_r, pd_r;
  always_comb begin
    rd_pipe_nxt   = step(rd_pipe_r, rdlat_w, rd_go, chop_w);
    wr_pipe_nxt   = step(wr_pipe_r, wrlat_w, wr_go, chop_w);
    rd_cnt_nxt    = cnt_step(rd_pipe_nxt[0], rd_cnt_r);
    wr_cnt_nxt    = cnt_step(wr_pipe_nxt[0], wr_cnt_r);
    st_nxt        = st_r;
    open_nxt      = open_r;
    tmr_nxt       = (tmr_r != 8'h00) ? 8'(tmr_r - 8'h01) : 8'h00;
    win_nxt       = (win_r != 5'h00) ? 5'(win_r - 5'h01) : 5'h00;
    term_async_nxt = (win_r == 5'h01) ? !term_async_r : term_async_r;
    unique case (st_r)
      ST_IDLE: begin
        if (!p.cke) begin
          if (p.cmd == CMD_REF) begin
            st_nxt = ST_SELF_REF;
          end else if (open_r != '0) begin
            st_nxt = ST_OPEN_PD;
          end else begin
            st_nxt = ST_PRE_PD;
            // Frozen DLL: termination goes async after the window
            win_nxt = cfg_r.slow_exit ? 5'(wrlat_w - 5'h02) : 5'h00;
          end
        end else if (p.cmd == CMD_OPEN) begin
          open_nxt[p.bank] = 1'b1;
        end else if (p.cmd == CMD_PRE) begin
          open_nxt[p.bank] = 1'b0;
        end else if (p.cmd == CMD_REF) begin
          st_nxt  = ST_REFRESH;
          tmr_nxt = 8'(RFC_CYC);
        end
      end
      // Commands are not decoded while the refresh runs
      ST_REFRESH: if (tmr_r <= 8'h01) st_nxt = ST_IDLE;
      ST_OPEN_PD: if (p.cke) st_nxt = ST_IDLE;
      ST_PRE_PD: begin
        if (p.cke && cfg_r.slow_exit) begin
          st_nxt  = ST_PD_EXIT;
          tmr_nxt = 8'(SLOW_CYC);
          win_nxt = term_async_r ? 5'(wrlat_w - 5'h02) : 5'h00;
        end else if (p.cke) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_PD_EXIT: if (tmr_r <= 8'h01) st_nxt = ST_IDLE;
      ST_SELF_REF: begin
        if (p.cke) begin
          st_nxt  = ST_SR_EXIT;
          tmr_nxt = 8'(SR_CYC);
        end
      end
      ST_SR_EXIT: if (tmr_r <= 8'h01) st_nxt = ST_IDLE;
      // Unused state code recovers to idle
      default:    st_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rd_pipe_r   <= '0;
      wr_pipe_r   <= '0;
      rd_cnt_r    <= 4'h0;
      wr_cnt_r    <= 4'h0;
      rd_on_r     <= 1'b0;
      wr_on_r     <= 1'b0;
      pd_r        <= 1'b0;
      st_r        <= ST_IDLE;
      open_r      <= '0;
      tmr_r       <= 8'h00;
      win_r       <= 5'h00;
      term_async_r <= 1'b0;
    end else begin
      rd_pipe_r   <= rd_pipe_nxt;
      wr_pipe_r   <= wr_pipe_nxt;
      rd_cnt_r    <= rd_cnt_nxt;
      wr_cnt_r    <= wr_cnt_nxt;
      rd_on_r     <= rd_cnt_nxt != 4'h0;
      wr_on_r     <= wr_cnt_nxt != 4'h0;
      pd_r        <= st_nxt inside {ST_OPEN_PD, ST_PRE_PD, ST_SELF_REF};
      st_r        <= st_nxt;
      open_r      <= open_nxt;
      tmr_r       <= tmr_nxt;
      win_r       <= win_nxt;
      term_async_r <= term_async_nxt;
    end
  end
  assign RD_VALID_OUT  = rd_on_r;
  assign WR_WINDOW_OUT = wr_on_r;
  assign PWR_DOWN_OUT  = pd_r;
  assign TERM_ASYNC_OUT = term_async_r;

  // Checks on the sequencing
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  chop_read_a: assert property (rd_go && chop_w && rdlat_w == 5
    |-> ##5 rd_on_r[*2]) else $error("chopped read window wrong");
  full_read_a: assert property (rd_go && !chop_w && rdlat_w == 5
    |-> ##5 rd_on_r[*4]) else $error("full read window wrong");
  fly_write_a: assert property (wr_go && cfg_r.burst == BF_FLY
    && !p.burst_chop_address_bit && wrlat_w == 5
    |-> ##1 wr_pipe_r[4] == 2'h3) else $error("per-command chop lost");
  read_lat_a: assert property (rd_go && rdlat_w == 9
    |-> ##9 rd_on_r) else $error("read latency wrong");
  write_lat_a: assert property (wr_go && wrlat_w == 9
    |-> ##9 wr_on_r) else $error("write latency wrong");
  open_pd_a: assert property (st_r == ST_IDLE && !p.cke
    && p.cmd != CMD_REF && open_r != '0
    |=> st_r == ST_OPEN_PD && pd_r) else $error("no active power-down");
  pd_exit_a: assert property (st_r == ST_PRE_PD && p.cke
    |=> st_r == (cfg_r.slow_exit ? ST_PD_EXIT : ST_IDLE))
    else $error("precharge power-down exit wrong");
  term_entry_a: assert property ((st_r == ST_IDLE && !p.cke
    && open_r == '0 && p.cmd != CMD_REF && cfg_r.slow_exit
    && wrlat_w == 5) ##1 (st_r == ST_PRE_PD)[*4] |-> term_async_r)
    else $error("async termination window wrong");
  term_exit_a: assert property (st_r == ST_PRE_PD && p.cke
    && cfg_r.slow_exit && term_async_r && wrlat_w == 5
    |=> term_async_r[*3] ##1 !term_async_r)
    else $error("sync termination not restored");
  chop_read_c: cover property (rd_go && chop_w);
  self_ref_c: cover property (st_r == ST_SELF_REF ##1 st_r == ST_SR_EXIT);
  slow_exit_c: cover property (st_r == ST_PD_EXIT && !term_async_r);
endmodule

// ---- sim/ctl_model.sv ----
// Controller model driving the sequencer's command pins.
// Assumes tasks are called from the bench; pins change after edges.
`timescale 1ns/1ps
module ctl_model
  import ddr3_seq_pkg::*;
(
  input  wire logic clk_in,
  output pins_t     pins_out
);
  // Idle pins: clock enabled, deselected
  initial begin
    pins_out = '0;
    pins_out.cke = 1'b1;
    pins_out.cmd = CMD_DES;
  end
  // Termination control held after every write; the sequencer has no
  // pin for it, so the duty is only kept on this side
  logic [2:0] term_cnt = 3'h0;
  logic       term_hold;
  always @(posedge clk_in) begin
    if (pins_out.cmd == CMD_WRITE) begin
      term_cnt <= TERM_HOLD_CYC;
    end else if (term_cnt != 3'h0) begin
      term_cnt <= term_cnt - 3'h1;
    end
  end
  assign term_hold = (pins_out.cmd == CMD_WRITE) || (term_cnt != 3'h0);
  // One command cycle, then a no-op with the chop bit flipped
  task automatic issue(input cmd_t c, input logic chop);
    @(posedge clk_in);
    pins_out.cmd <= c;
    pins_out.burst_chop_address_bit <= chop;
    @(posedge clk_in);
    pins_out.cmd <= CMD_NOOP;
    pins_out.burst_chop_address_bit <= ~chop; // Stale bit not held
  endtask
  // Clock enable change with a no-op beside it
  task automatic set_cke(input logic v);
    @(posedge clk_in);
    pins_out.cke <= v;
    pins_out.cmd <= CMD_NOOP;
  endtask
  // Refresh, then only no-ops until the cycle time is over
  task automatic refresh;
    issue(CMD_REF, 1'b0);
    repeat (RFC_CYC + 2) @(posedge clk_in);
  endtask
  // Self-refresh entry: refresh command with clock enable low
  task automatic sr_enter;
    @(posedge clk_in);
    pins_out.cmd <= CMD_REF;
    pins_out.cke <= 1'b0;
    @(posedge clk_in);
    pins_out.cmd <= CMD_NOOP;
  endtask
  // Exit sends no-ops only, so no locked-loop command comes early
  task automatic sr_exit;
    set_cke(1'b1);
    repeat (SR_CYC + 3) @(posedge clk_in);
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Bench for the command sequencer: bursts, latencies, refresh, power-down.
// Assumes ctl_model drives the command pins; register port driven here.
`timescale 1ns/1ps
module tb_top;
  import ddr3_seq_pkg::*;
  logic        clk_in;
  logic        rstn_in;
  logic [3:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata;
  logic        rd_v;
  logic        wr_w;
  logic        pd;
  logic        term_a;
  pins_t       pins;
  int          err_total;
  int          checked;

  ddr3_seq dut (
    .CLK_IN        (clk_in),
    .RSTN_IN       (rstn_in),
    .PINS_IN       (pins),
    .ADDR_IN       (addr_in),
    .WDATA_IN      (wdata_in),
    .WR_IN         (wr_in),
    .RD_IN         (rd_in),
    .RDATA_OUT     (rdata),
    .RD_VALID_OUT  (rd_v),
    .WR_WINDOW_OUT (wr_w),
    .PWR_DOWN_OUT  (pd),
    .TERM_ASYNC_OUT (term_a)
  );
  ctl_model ctl (.clk_in(clk_in), .pins_out(pins));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic chk(input string n, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data is registered in the cycle after the strobe and held until the next read
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata;
  endtask
  // Config word; callers never pass the reserved burst code
  function automatic logic [31:0] cfg(logic [1:0] f, add, logic se);
    return {19'h0_0000, se, add, CFG_RESET[9:2], f};
  endfunction
  // Cycles until a data window opens, then its width; bounded
  task automatic meas(input logic rd, output int lat, wid);
    lat = 0;
    wid = 0;
    while ((rd ? rd_v : wr_w) !== 1'b1 && lat < 40) begin
      @(posedge clk_in);
      #1 lat++;
    end
    while ((rd ? rd_v : wr_w) === 1'b1 && wid < 20) begin
      @(posedge clk_in);
      #1 wid++;
    end
  endtask

  task automatic t_reset;
    logic [31:0] d;
    reg_rd(ADDR_CFG, d);
    chk("cfg reset", {19'h0_0000, CFG_RESET}, d);
    reg_rd(4'h8, d);
    chk("unmapped read", 32'h0000_0000, d);
  endtask
  // Fixed and per-command burst selection, chop bit ignored when fixed
  task automatic t_burst;
    logic [1:0] fld [4] = '{BF_FULL, BF_FLY, BF_FLY, BF_CHOP};
    logic       chp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int         lat;
    int         wid;
    for (int i = 0; i < 4; i++) begin
      reg_wr(ADDR_CFG, cfg(fld[i], 2'h0, 1'b0));
      ctl.issue(CMD_READ, chp[i]);
      meas(1'b1, lat, wid);
      chk("read width", (i < 2) ? FULL_CYC : CHOP_CYC, 32'(wid));
      ctl.issue(CMD_WRITE, chp[i]);
      meas(1'b0, lat, wid);
      chk("write width", (i < 2) ? FULL_CYC : CHOP_CYC, 32'(wid));
    end
  endtask
  // Eight-beat then chopped read four clocks apart: windows abut
  task automatic t_fly;
    int hi;
    hi = 0;
    reg_wr(ADDR_CFG, cfg(BF_FLY, 2'h0, 1'b0));
    ctl.issue(CMD_READ, 1'b1);
    repeat (2) @(posedge clk_in);
    ctl.issue(CMD_READ, 1'b0);
    repeat (30) begin
      @(posedge clk_in);
      #1 hi += int'(rd_v === 1'b1);
    end
    chk("mixed width", 32'(FULL_CYC + CHOP_CYC), 32'(hi));
  endtask
  task automatic t_latency;
    int r0, r1, r2, w0, w1, x;
    reg_wr(ADDR_CFG, cfg(BF_FULL, 2'h0, 1'b0));
    ctl.issue(CMD_READ, 1'b0);
    meas(1'b1, r0, x);
    ctl.issue(CMD_WRITE, 1'b0);
    meas(1'b0, w0, x);
    reg_wr(ADDR_CFG, cfg(BF_FULL, 2'h1, 1'b0));
    ctl.issue(CMD_READ, 1'b0);
    meas(1'b1, r1, x);
    ctl.issue(CMD_WRITE, 1'b0);
    meas(1'b0, w1, x);
    x = CFG_RESET.base_read_latency - 1;
    chk("read lat step", 32'(x), 32'(r1 - r0));
    chk("write lat step", 32'(x), 32'(w1 - w0));
    // Additive latency of base minus two
    reg_wr(ADDR_CFG, cfg(BF_FULL, 2'h2, 1'b0));
    ctl.issue(CMD_READ, 1'b0);
    meas(1'b1, r2, x);
    x = CFG_RESET.base_read_latency - 2;
    chk("read lat step two", 32'(x), 32'(r2 - r0));
  endtask
  // A read too soon after refresh is dropped; a later one is served
  task automatic t_refresh;
    int lat, wid;
    reg_wr(ADDR_CFG, cfg(BF_FULL, 2'h0, 1'b0));
    ctl.issue(CMD_REF, 1'b0);
    ctl.issue(CMD_READ, 1'b0);
    meas(1'b1, lat, wid);
    chk("read in refresh", 32'h0, 32'(wid));
    ctl.refresh;
    ctl.issue(CMD_READ, 1'b0);
    meas(1'b1, lat, wid);
    chk("read after refresh", 32'(FULL_CYC), 32'(wid));
  endtask
  task automatic t_power;
    logic [31:0] d;
    reg_wr(ADDR_CFG, cfg(BF_FULL, 2'h0, 1'b1));
    ctl.issue(CMD_OPEN, 1'b0);
    ctl.set_cke(1'b0);
    repeat (4) @(posedge clk_in);
    reg_rd(ADDR_STAT, d);
    chk("active pd", 32'h2, {29'h0, d[2:0]});
    chk("pd flag", 32'h1, {31'h0, pd});
    ctl.set_cke(1'b1);
    repeat (3) @(posedge clk_in);
    ctl.issue(CMD_PRE, 1'b0);
    ctl.set_cke(1'b0);
    repeat (3) @(posedge clk_in);
    reg_rd(ADDR_STAT, d);
    chk("precharge pd", 32'h3, {29'h0, d[2:0]});
    chk("term early", 32'h0, {31'h0, term_a});
    repeat (6) @(posedge clk_in);
    #1 chk("term async", 32'h1, {31'h0, term_a});
    ctl.set_cke(1'b1);
    #1 chk("term held", 32'h1, {31'h0, term_a});
    repeat (8) @(posedge clk_in);
    #1 chk("term sync", 32'h0, {31'h0, term_a});
    chk("pd exit", 32'h0, {31'h0, pd});
    ctl.sr_enter;
    repeat (4) @(posedge clk_in);
    #1 chk("self refresh", 32'h1, {31'h0, pd});
    ctl.sr_exit;
    #1 chk("sr exit", 32'h0, {31'h0, pd});
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Whole run needs under 500 cycles; this bound of 4000 cycles is far above it
  initial begin
    #100us;
    err_total++;
    end_of_test;
  end
  initial begin
    rstn_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 32'h0000_0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset;
    t_burst;
    t_fly;
    t_latency;
    t_refresh;
    t_power;
    end_of_test;
  end
endmodule
